// ==== acis_pkg.sv ====
package acis_pkg;
   // ****************************************************************
   // Register map (printed offsets 7..14 are not multiples of four,
   // so each is an index and the byte address is four times it)
   // ****************************************************************
   localparam logic [7:0] IDX_STATUS_ONE  = 8'h07;
   localparam logic [7:0] IDX_STATUS_TWO  = 8'h08;
   localparam logic [7:0] IDX_MASK_ONE    = 8'h09;
   localparam logic [7:0] IDX_MODE1_MSB   = 8'h0a;
   localparam logic [7:0] IDX_MODE1_LSB   = 8'h0b;
   localparam logic [7:0] IDX_MASK_TWO    = 8'h0c;
   localparam logic [7:0] IDX_MODE2_MSB   = 8'h0d;
   localparam logic [7:0] IDX_MODE2_LSB   = 8'h0e;
   localparam logic [7:0] IDX_CONFIG      = 8'h10;
   localparam int         ADDR_W          = 8;
   localparam int         REG_W           = 8;

   // ****************************************************************
   // Field layout and reset values
   // ****************************************************************
   localparam logic [7:0] RST_REG         = 8'h00;
   localparam logic [7:0] TWO_USED_BITS   = 8'h3f;
   localparam int         BIT_TX_SLIP     = 7;
   localparam int         BIT_OUT_SLIP    = 6;
   localparam int         BIT_RATE        = 5;
   localparam int         BIT_OVR_LEFT    = 4;
   localparam int         BIT_OVR_RIGHT   = 3;
   localparam int         BIT_CS_DE       = 2;
   localparam int         BIT_CS_EF       = 1;
   localparam int         BIT_RX_ERR      = 0;
   localparam int         BIT_FIFO_OVF    = 5;
   localparam int         BIT_TRACKING    = 4;
   localparam int         BIT_U_DE        = 3;
   localparam int         BIT_U_EF        = 2;
   localparam int         BIT_QSUB        = 1;
   localparam int         BIT_U_OVW       = 0;
   localparam int         CFG_BLOCK_MODE  = 0;
   localparam int         CFG_SRC_USED    = 1;
   localparam int         CFG_OUT_SLAVE   = 2;
   localparam int         CFG_TX_ASYNC    = 3;
   localparam int         CFG_OUT_ASYNC   = 4;
   localparam int         RATIO_LIMIT     = 3;
   localparam int         RATIO_W         = 8;

   // ****************************************************************
   // Edge select codes and bus answers
   // ****************************************************************
   typedef enum logic [1:0] {
      EDGE_RISE  = 2'h0,
      EDGE_FALL  = 2'h1,
      EDGE_LEVEL = 2'h2,
      EDGE_RSVD  = 2'h3
   } acis_edge_e;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   localparam int         QSUB_FRAMES     = 588;
endpackage : acis_pkg

// ==== acis_sticky_bit.sv ====
`timescale 1ns/1ps
module acis_sticky_bit
   import acis_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstN,
   // Event source and control
   input  wire logic       srcLevel,
   input  wire logic       maskEn,
   input  wire logic [1:0] edgeSel,
   input  wire logic       readClr,
   // Status
   output logic            flag
);
   logic srcPrev_q;
   logic flag_q;
   logic hit;

   // Previous source value for edge detection
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         srcPrev_q <= 1'b0;
      end else begin
         srcPrev_q <= srcLevel;
      end
   end

   // Qualified event per edge select; reserved code never fires
   always_comb begin
      case (edgeSel)
         EDGE_RISE:  hit = srcLevel & ~srcPrev_q;
         EDGE_FALL:  hit = ~srcLevel & srcPrev_q;
         EDGE_LEVEL: hit = srcLevel;
         default:    hit = 1'b0;
      endcase
   end

   // Sticky flag: a new event outranks the read clear
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         flag_q <= 1'b0;
      end else if (!maskEn) begin
         flag_q <= 1'b0;
      end else if (hit) begin
         flag_q <= 1'b1;
      end else if (readClr) begin
         flag_q <= 1'b0;
      end
   end

   assign flag = flag_q & maskEn;
endmodule : acis_sticky_bit

// ==== acis_sat_clip.sv ====
`timescale 1ns/1ps
module acis_sat_clip (
   // Wide converter result
   input  wire logic signed [25:0] wide,
   // Clipped sample and overrange
   output logic signed [23:0]      sample,
   output logic                    over
);
   localparam logic signed [23:0] POS_FS = 24'sh7fffff;
   localparam logic signed [23:0] NEG_FS = -24'sh7fffff - 24'sh000001;

   // Clip to full scale; overrange when upper bits disagree with sign
   always_comb begin
      over   = (wide > 26'(POS_FS)) || (wide < 26'(NEG_FS));
      if (wide > 26'(POS_FS)) begin
         sample = POS_FS;
      end else if (wide < 26'(NEG_FS)) begin
         sample = NEG_FS;
      end else begin
         sample = wide[23:0];
      end
   end
endmodule : acis_sat_clip

// ==== acis_irq_status.sv ====
// Contract
// - Status bit is 1 if its event happened since last read, else 0.
// - Reading a status register clears it, except active level-mode sources.
// - Masked status bits read 0 and never latch.
// - Mask 1 lets event reach status and pin; 0 blocks both.
// - Mask aligns with status bits; status and mask reset to zero.
// - Tx slip without converter: on slip with async clock, or on block start.
// - Output slip on slave async slip, or ratio mismatch with converter used in slave mode.
// - Rate range flag when either sample rate ratio exceeds three.
// - Left and right overrange flags latch; samples clip to full scale.
// - Channel-status transfer flags sourced by transfer in progress.
// - Receiver error flag latches on any receiver error.
// - Status two bits 7,6 read 0; FIFO overflow latches bit 5.
// - Tracking flag latches while converter follows changing rate.
// - User transfer flags sourced by transfers, only in block mode.
// - Q-subcode ready latches; host reads block within 588 frames.
// - User FIFO overwrite flag latches on overwrite.
// - Two-bit edge select per bit: rise, fall, level, reserved; reset 00.
`timescale 1ns/1ps
module acis_irq_status
   import acis_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               nrst,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W+1:0]  awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   // AXI4-Lite write response
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W+1:0]  araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Event sources from the datapath (pins, hence synchronised)
   input  wire logic               txSlipEvt,
   input  wire logic               txBlockStart,
   input  wire logic               outSlipEvt,
   input  wire logic               clkRatioMismatch,
   input  wire logic               csXferDtoE,
   input  wire logic               csXferEtoF,
   input  wire logic               rxErrAny,
   input  wire logic               fifoOverflow,
   input  wire logic               converterTracking,
   input  wire logic               userXferDtoE,
   input  wire logic               userXferEtoF,
   input  wire logic               qsubReady,
   input  wire logic               userFifoOverwrite,
   // Converter rate ratio and raw outputs (same clock)
   input  wire logic [RATIO_W-1:0] rateInOverOut,
   input  wire logic [RATIO_W-1:0] rateOutOverIn,
   input  wire logic signed [25:0] leftWide,
   input  wire logic signed [25:0] rightWide,
   // Clipped samples and interrupt pin
   output logic signed [23:0]      leftSample,
   output logic signed [23:0]      rightSample,
   output logic                    irqOut
);
   // ****************************************************************
   // Reset release and input synchronisers
   // ****************************************************************
   localparam int NSYNC = 13;
   logic [1:0]       rstSync_q;
   logic             rstN;
   logic [NSYNC-1:0] syncA_q;
   logic [NSYNC-1:0] syncB_q;
   logic [NSYNC-1:0] rawIn;

   // Reset asserts at once and releases after two edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstN = rstSync_q[1];

   assign rawIn = {txSlipEvt, txBlockStart, outSlipEvt, clkRatioMismatch, csXferDtoE,
                   csXferEtoF, rxErrAny, fifoOverflow, converterTracking, userXferDtoE,
                   userXferEtoF, qsubReady, userFifoOverwrite};

   // Two stage synchroniser; only syncB_q is read by logic
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= rawIn;
         syncB_q <= syncA_q;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [REG_W-1:0] maskOne_q;
   logic [REG_W-1:0] maskTwo_q;
   logic [REG_W-1:0] mode1Msb_q;
   logic [REG_W-1:0] mode1Lsb_q;
   logic [REG_W-1:0] mode2Msb_q;
   logic [REG_W-1:0] mode2Lsb_q;
   logic [REG_W-1:0] config_q;
   logic [REG_W-1:0] statOne;
   logic [REG_W-1:0] statTwo;
   logic [REG_W-1:0] srcOne;
   logic [REG_W-1:0] srcTwo;
   logic             readOne;
   logic             readTwo;
   logic             overL;
   logic             overR;

   // ****************************************************************
   // Event sources
   // ****************************************************************
   logic txAsync, outAsync, srcUsed, outSlave, blockMode;
   assign blockMode = config_q[CFG_BLOCK_MODE];
   assign srcUsed   = config_q[CFG_SRC_USED];
   assign outSlave  = config_q[CFG_OUT_SLAVE];
   assign txAsync   = config_q[CFG_TX_ASYNC];
   assign outAsync  = config_q[CFG_OUT_ASYNC];

   logic signed [23:0] leftSampleC;
   logic signed [23:0] rightSampleC;

   // Converter clipping is combinational; flags latch below
   acis_sat_clip uClipL (
      .wide   (leftWide),
      .sample (leftSampleC),
      .over   (overL)
   );
   acis_sat_clip uClipR (
      .wide   (rightWide),
      .sample (rightSampleC),
      .over   (overR)
   );

   // Clipped samples registered as data outputs
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         leftSample  <= '0;
         rightSample <= '0;
      end else begin
         leftSample  <= leftSampleC;
         rightSample <= rightSampleC;
      end
   end

   // Source conditions for status one
   always_comb begin
      srcOne = RST_REG;
      srcOne[BIT_TX_SLIP]   = (syncB_q[12] & ~srcUsed & txAsync)
                            | (syncB_q[11] & ~srcUsed);
      srcOne[BIT_OUT_SLIP]  = (syncB_q[10] & outSlave & outAsync)
                            | (syncB_q[9] & srcUsed & outSlave);
      srcOne[BIT_RATE]      = (rateInOverOut > RATIO_W'(RATIO_LIMIT))
                            | (rateOutOverIn > RATIO_W'(RATIO_LIMIT));
      srcOne[BIT_OVR_LEFT]  = overL;
      srcOne[BIT_OVR_RIGHT] = overR;
      srcOne[BIT_CS_DE]     = syncB_q[8];
      srcOne[BIT_CS_EF]     = syncB_q[7];
      srcOne[BIT_RX_ERR]    = syncB_q[6];
   end

   // Source conditions for status two; top bits stay zero
   always_comb begin
      srcTwo = RST_REG;
      srcTwo[BIT_FIFO_OVF] = syncB_q[5];
      srcTwo[BIT_TRACKING] = syncB_q[4];
      srcTwo[BIT_U_DE]     = syncB_q[3] & blockMode;
      srcTwo[BIT_U_EF]     = syncB_q[2] & blockMode;
      srcTwo[BIT_QSUB]     = syncB_q[1];
      srcTwo[BIT_U_OVW]    = syncB_q[0];
   end

   // ****************************************************************
   // Sticky status bits, one cell per bit
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < REG_W; gi++) begin : gOne
         acis_sticky_bit uBit (
            .clk     (clk),
            .rstN    (rstN),
            .srcLevel(srcOne[gi]),
            .maskEn  (maskOne_q[gi]),
            .edgeSel ({mode1Msb_q[gi], mode1Lsb_q[gi]}),
            .readClr (readOne),
            .flag    (statOne[gi])
         );
      end
      for (gi = 0; gi < REG_W; gi++) begin : gTwo
         acis_sticky_bit uBit (
            .clk     (clk),
            .rstN    (rstN),
            .srcLevel(srcTwo[gi]),
            .maskEn  (maskTwo_q[gi] & TWO_USED_BITS[gi]),
            .edgeSel ({mode2Msb_q[gi], mode2Lsb_q[gi]}),
            .readClr (readTwo),
            .flag    (statTwo[gi])
         );
      end
   endgenerate

   // Interrupt pin; flags are already masked
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= (|statOne) | (|statTwo);
      end
   end

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   logic             awHeld_q, wHeld_q;
   logic [ADDR_W-1:0] awIdx_q;
   logic [REG_W-1:0] wByte_q;
   logic             wLane_q;
   logic             doWrite;

   assign awready = ~awHeld_q & ~bvalid;
   assign wready  = ~wHeld_q & ~bvalid;
   assign doWrite = awHeld_q & wHeld_q & ~bvalid;

   // Capture address and data in either order
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awIdx_q  <= '0;
         wByte_q  <= '0;
         wLane_q  <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awIdx_q  <= awaddr[ADDR_W+1:2];
         end else if (doWrite) begin
            awHeld_q <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wByte_q <= wdata[REG_W-1:0];
            wLane_q <= wstrb[0];
         end else if (doWrite) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   logic wrKnown;
   always_comb begin
      case (awIdx_q)
         IDX_MASK_ONE, IDX_MASK_TWO, IDX_MODE1_MSB, IDX_MODE1_LSB,
         IDX_MODE2_MSB, IDX_MODE2_LSB, IDX_CONFIG, IDX_STATUS_ONE,
         IDX_STATUS_TWO: wrKnown = 1'b1;
         default:        wrKnown = 1'b0;
      endcase
   end

   // Writable registers; status is read-only and ignores writes
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         maskOne_q  <= RST_REG;
         maskTwo_q  <= RST_REG;
         mode1Msb_q <= RST_REG;
         mode1Lsb_q <= RST_REG;
         mode2Msb_q <= RST_REG;
         mode2Lsb_q <= RST_REG;
         config_q   <= RST_REG;
      end else if (doWrite && wLane_q) begin
         case (awIdx_q)
            IDX_MASK_ONE:  maskOne_q  <= wByte_q;
            IDX_MASK_TWO:  maskTwo_q  <= wByte_q & TWO_USED_BITS;
            IDX_MODE1_MSB: mode1Msb_q <= wByte_q;
            IDX_MODE1_LSB: mode1Lsb_q <= wByte_q;
            IDX_MODE2_MSB: mode2Msb_q <= wByte_q & TWO_USED_BITS;
            IDX_MODE2_LSB: mode2Lsb_q <= wByte_q & TWO_USED_BITS;
            IDX_CONFIG:    config_q   <= wByte_q;
            default:       config_q   <= config_q;
         endcase
      end
   end

   // Write response
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= wrKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   logic [ADDR_W-1:0] arIdx;
   logic [REG_W-1:0]  rdByte;
   logic              rdKnown;
   assign arready = ~rvalid;
   assign arIdx   = araddr[ADDR_W+1:2];
   assign readOne = arvalid & arready & (arIdx == IDX_STATUS_ONE);
   assign readTwo = arvalid & arready & (arIdx == IDX_STATUS_TWO);

   // Read mux
   always_comb begin
      rdKnown = 1'b1;
      case (arIdx)
         IDX_STATUS_ONE: rdByte = statOne;
         IDX_STATUS_TWO: rdByte = statTwo;
         IDX_MASK_ONE:   rdByte = maskOne_q;
         IDX_MASK_TWO:   rdByte = maskTwo_q;
         IDX_MODE1_MSB:  rdByte = mode1Msb_q;
         IDX_MODE1_LSB:  rdByte = mode1Lsb_q;
         IDX_MODE2_MSB:  rdByte = mode2Msb_q;
         IDX_MODE2_LSB:  rdByte = mode2Lsb_q;
         IDX_CONFIG:     rdByte = config_q;
         default: begin
            rdByte  = RST_REG;
            rdKnown = 1'b0;
         end
      endcase
   end

   // Read data held until taken
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= {24'h000000, rdByte};
         rresp  <= rdKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : acis_irq_status

// ==== acis_irq_status_assertions.sv ====
`timescale 1ns/1ps
module acis_irq_status_assertions
   import acis_pkg::*;
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               nrst,
   // Register bus
   input wire logic [ADDR_W+1:0]  awaddr,
   input wire logic               awvalid,
   input wire logic               awready,
   input wire logic [31:0]        wdata,
   input wire logic [3:0]         wstrb,
   input wire logic               wvalid,
   input wire logic               wready,
   input wire logic [1:0]         bresp,
   input wire logic               bvalid,
   input wire logic               bready,
   input wire logic [ADDR_W+1:0]  araddr,
   input wire logic               arvalid,
   input wire logic               arready,
   input wire logic [31:0]        rdata,
   input wire logic               rvalid,
   input wire logic               rready,
   // Samples and pin
   input wire logic signed [25:0] leftWide,
   input wire logic signed [25:0] rightWide,
   input wire logic signed [23:0] leftSample,
   input wire logic signed [23:0] rightSample,
   input wire logic               irqOut
);
   // *****************************
   // Helper state
   // *****************************
   logic [1:0] upCnt_q;
   logic [7:0] rdIdx_q;
   logic [7:0] m1_q;
   logic [5:0] m2_q;
   logic [2:0] zeroCnt_q;
   wire        up     = upCnt_q == 2'h3;
   wire        wrTake = awvalid && awready && wvalid && wready;

   // Own clip reference
   function automatic logic [23:0] clip(input logic signed [25:0] v);
      if (v > 26'sd8388607) return 24'h7fffff;
      if (v < -26'sd8388608) return 24'h800000;
      return v[23:0];
   endfunction : clip

   // Outputs trusted after internal reset release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) upCnt_q <= 2'h0;
      else if (!up) upCnt_q <= upCnt_q + 2'h1;
   end

   // Mask and read index shadows
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         m1_q    <= 8'h00;
         m2_q    <= 6'h00;
         rdIdx_q <= 8'h00;
      end else begin
         if (wrTake && wstrb[0] && awaddr[9:2] == IDX_MASK_ONE) m1_q <= wdata[7:0];
         if (wrTake && wstrb[0] && awaddr[9:2] == IDX_MASK_TWO) m2_q <= wdata[5:0];
         if (arvalid && arready) rdIdx_q <= araddr[9:2];
      end
   end

   // Cycles with all masks clear, saturating
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) zeroCnt_q <= 3'h0;
      else if (m1_q != 8'h00 || m2_q != 6'h00) zeroCnt_q <= 3'h0;
      else if (zeroCnt_q != 3'h7) zeroCnt_q <= zeroCnt_q + 3'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("rdata upper bits set");
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bvalid dropped");
   chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("rvalid dropped");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_write_answer: assert property (wrTake |-> ##[1:2] bvalid)
      else $error("write answer late");
   chk_clip_left: assert property (up |=> leftSample == clip($past(leftWide)))
      else $error("left clip");
   chk_clip_right: assert property (up |=> rightSample == clip($past(rightWide)))
      else $error("right clip");
   chk_status_one_mask: assert property (rvalid && rdIdx_q == IDX_STATUS_ONE
      |-> (rdata[7:0] & ~m1_q) == 8'h00) else $error("masked bit set in status one");
   chk_status_two_mask: assert property (rvalid && rdIdx_q == IDX_STATUS_TWO
      |-> (rdata[7:0] & ~{2'b00, m2_q}) == 8'h00) else $error("masked bit set in status two");
   chk_irq_masked: assert property (zeroCnt_q == 3'h7 |-> !irqOut)
      else $error("irq with masks clear");
endmodule : acis_irq_status_assertions

bind acis_irq_status acis_irq_status_assertions chk (.*);

// ==== acis_host_model.sv ====
`timescale 1ns/1ps
module acis_host_model
   import acis_pkg::*;
(
   // Clock
   input wire logic               clk,
   // Write channels
   output logic [ADDR_W+1:0]      awaddr,
   output logic                   awvalid,
   input wire logic               awready,
   output logic [31:0]            wdata,
   output logic [3:0]             wstrb,
   output logic                   wvalid,
   input wire logic               wready,
   input wire logic [1:0]         bresp,
   input wire logic               bvalid,
   output logic                   bready,
   // Read channels
   output logic [ADDR_W+1:0]      araddr,
   output logic                   arvalid,
   input wire logic               arready,
   input wire logic [31:0]        rdata,
   input wire logic [1:0]         rresp,
   input wire logic               rvalid,
   output logic                   rready
);
   // Idle bus
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   end

   // One write
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
      bit aw, w, b;
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h0, d};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!b) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            b = 1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      @(posedge clk);
   endtask : wr

   // One read, back to back
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      bit a, g;
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!g) begin
         @(posedge clk);
         if (!a && arready) begin
            a = 1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            g = 1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      @(posedge clk);
   endtask : rd
endmodule : acis_host_model

// ==== acis_irq_status_tb.sv ====
`timescale 1ns/1ps
module acis_irq_status_tb;
   import acis_pkg::*;
   // *****************************
   // Signals
   // *****************************
   logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irqOut;
   logic [ADDR_W+1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [12:0] ev;
   logic [RATIO_W-1:0] rateInOverOut, rateOutOverIn;
   logic signed [25:0] leftWide, rightWide;
   logic signed [23:0] leftSample, rightSample;
   int mismatches, n_compared;
   // Expected {status two, status one} per source
   logic [15:0] expTab [13] = '{16'h0080, 16'h0080, 16'h0040, 16'h0000, 16'h0004,
      16'h0002, 16'h0001, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100};

   acis_irq_status dut (.*, .txSlipEvt(ev[0]), .txBlockStart(ev[1]), .outSlipEvt(ev[2]),
      .clkRatioMismatch(ev[3]), .csXferDtoE(ev[4]), .csXferEtoF(ev[5]), .rxErrAny(ev[6]),
      .fifoOverflow(ev[7]), .converterTracking(ev[8]), .userXferDtoE(ev[9]),
      .userXferEtoF(ev[10]), .qsubReady(ev[11]), .userFifoOverwrite(ev[12]));
   acis_host_model host (.*);

   // *****************************
   // Checking tasks
   // *****************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
      host.wr(idx, d, rsp);
      chk("bresp", 32'(RESP_OKAY), 32'(rsp));
   endtask : wrReg
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
      host.rd(idx, rdv, rsp);
      chk("rdata", {24'h0, e}, rdv);
      chk("rresp", 32'(RESP_OKAY), 32'(rsp));
   endtask : rdChk
   // One-cycle event, then sync, latch, pin
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : pulse
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end

   // Main sequence
   initial begin
      {nrst, ev, rateInOverOut, rateOutOverIn, leftWide, rightWide} = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 7; i < 16; i++) rdChk(i == 15 ? IDX_CONFIG : 8'(i), 8'h00);
      host.rd(8'h3f, rdv, rsp);
      chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
      chk("unmapped data", 32'h0, rdv);
      pulse(6);
      rdChk(IDX_STATUS_ONE, 8'h00);
      chk("irq", 32'h0, 32'(irqOut));
      wrReg(IDX_MASK_ONE, 8'ha5);
      rdChk(IDX_MASK_ONE, 8'ha5);
      wrReg(IDX_STATUS_ONE, 8'hff);
      rdChk(IDX_STATUS_ONE, 8'h00);
      wrReg(IDX_MASK_ONE, 8'hff);
      wrReg(IDX_MASK_TWO, 8'h3f);
      wrReg(IDX_CONFIG, 8'h1d);
      // Each source alone, then the clear
      for (int i = 0; i < 13; i++) begin
         pulse(i);
         chk("irq", 32'(expTab[i] != 16'h0), 32'(irqOut));
         rdChk(IDX_STATUS_ONE, expTab[i][7:0]);
         rdChk(IDX_STATUS_TWO, expTab[i][15:8]);
         rdChk(IDX_STATUS_ONE, 8'h00);
      end
      chk("irq", 32'h0, 32'(irqOut));
      wrReg(IDX_CONFIG, 8'h1e);
      pulse(3);
      pulse(0);
      pulse(9);
      rdChk(IDX_STATUS_ONE, 8'h40);
      rdChk(IDX_STATUS_TWO, 8'h00);
      rateInOverOut <= 8'h03;
      repeat (4) @(posedge clk);
      rdChk(IDX_STATUS_ONE, 8'h00);
      rateOutOverIn <= 8'h04;
      repeat (4) @(posedge clk);
      rateOutOverIn <= 8'h00;
      rdChk(IDX_STATUS_ONE, 8'h20);
      leftWide  <= 26'sh1000000;
      rightWide <= 26'sh3000000;
      repeat (4) @(posedge clk);
      chk("left", 32'h007fffff, {8'h0, leftSample});
      chk("right", 32'h00800000, {8'h0, rightSample});
      leftWide  <= 26'sh0;
      rightWide <= 26'sh0;
      repeat (4) @(posedge clk);
      rdChk(IDX_STATUS_ONE, 8'h18);
      // Edge codes on receiver error bit
      for (int c = 0; c < 4; c++) begin
         wrReg(IDX_MODE1_MSB, {7'h0, c[1]});
         wrReg(IDX_MODE1_LSB, {7'h0, c[0]});
         ev[6] <= 1'b1;
         repeat (5) @(posedge clk);
         rdChk(IDX_STATUS_ONE, {7'h0, c == 0 || c == 2});
         ev[6] <= 1'b0;
         repeat (5) @(posedge clk);
         rdChk(IDX_STATUS_ONE, {7'h0, c == 1 || c == 2});
         rdChk(IDX_STATUS_ONE, 8'h00);
      end
      wrReg(IDX_MODE1_MSB, 8'h00);
      wrReg(IDX_MODE1_LSB, 8'h00);
      pulse(6);
      wrReg(IDX_MASK_ONE, 8'h00);
      wrReg(IDX_MASK_TWO, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, 32'(irqOut));
      rdChk(IDX_STATUS_ONE, 8'h00);
      conclude();
   end
endmodule : acis_irq_status_tb
